// ### dirp_sync.sv
// constants package and input synchroniser for the interrupt and reset pin logic
package dirp_pkg;
  // register port geometry
  localparam int unsigned DIRP_ADDR_W = 4;
  localparam int unsigned DIRP_DATA_W = 16;
  localparam int unsigned DIRP_NUM_IRQ = 4;
  localparam int unsigned DIRP_IDX_W = 2;
  // register offsets
  localparam logic [3:0] DIRP_OFS_CTRL = 4'h0;
  localparam logic [3:0] DIRP_OFS_MASK = 4'h1;
  localparam logic [3:0] DIRP_OFS_FLAG = 4'h2;
  localparam logic [3:0] DIRP_OFS_EVT_STATUS = 4'h3;
  localparam logic [3:0] DIRP_OFS_EVT_MASK = 4'h4;
  localparam logic [3:0] DIRP_OFS_PC = 4'h5;
  // control register fields
  localparam int unsigned DIRP_CTRL_GMASK_BIT = 0;
  localparam int unsigned DIRP_CTRL_MODE_BIT = 1;
  // event status fields
  localparam int unsigned DIRP_EVT_W = 3;
  localparam int unsigned DIRP_EVT_USER_BIT = 0;
  localparam int unsigned DIRP_EVT_NMI_BIT = 1;
  localparam int unsigned DIRP_EVT_RESET_BIT = 2;
  // reset values
  localparam logic DIRP_GMASK_RESET = 1'b1;
  localparam logic DIRP_MODE_RESET = 1'b0;
  localparam logic [3:0] DIRP_MASK_RESET = 4'h0;
  localparam logic [3:0] DIRP_FLAG_RESET = 4'h0;
  localparam logic [2:0] DIRP_EVT_RESET = 3'h0;
  localparam logic [15:0] DIRP_DATA_RESET = 16'h0000;
  // vector addresses
  localparam logic [15:0] DIRP_RESET_VEC = 16'hFF80;
  localparam logic [15:0] DIRP_NMI_VEC = 16'hFF88;
  localparam logic [15:0] DIRP_USER_VEC_BASE = 16'hFFC0;
  // synchroniser width and idle level of active-low pins
  localparam int unsigned DIRP_SYNC_W = 6;
  localparam logic [5:0] DIRP_SYNC_IDLE = 6'h3F;
  // core sequencing states, gray along reset -> run -> vector
  typedef enum logic [1:0]
  {
    DIRP_ST_RESET = 2'b00,
    DIRP_ST_RUN = 2'b01,
    DIRP_ST_VECTOR = 2'b11
  } dirp_state_t;
endpackage : dirp_pkg

`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// two-flop synchroniser, resets to the idle (high) level of active-low pins
module dirp_sync
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [dirp_pkg::DIRP_SYNC_W-1:0] async_in,
  output logic [dirp_pkg::DIRP_SYNC_W-1:0] sync_out
);
  import dirp_pkg::*;

  logic [DIRP_SYNC_W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= DIRP_SYNC_IDLE;
      sync_out <= DIRP_SYNC_IDLE;
    end
    else if (ce)
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : dirp_sync

// ### dirp_irq_reset.sv
// pin-level interrupt, acknowledge and reset sequencing of the signal processor core
`timescale 1ns/10ps
module dirp_irq_reset
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic user_irq_in_0,
  input wire logic user_irq_in_1,
  input wire logic user_irq_in_2,
  input wire logic user_irq_in_3,
  input wire logic nmi_in_n,
  input wire logic reset_in_n,
  input wire logic hold_in_n,
  input wire logic out_disable_n,
  input wire logic [dirp_pkg::DIRP_DATA_W-1:0] core_data_out,
  input wire logic core_data_drive,
  input wire logic [dirp_pkg::DIRP_ADDR_W-1:0] reg_addr,
  input wire logic [dirp_pkg::DIRP_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dirp_pkg::DIRP_DATA_W-1:0] reg_rdata,
  output logic irq_acknowledge_out,
  output logic irq_acknowledge_oe,
  output logic [15:0] addr_bus_out,
  output logic [dirp_pkg::DIRP_DATA_W-1:0] data_bus_out,
  output logic data_bus_oe,
  output logic core_halted,
  output logic irq_out
);
  import dirp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [DIRP_SYNC_W-1:0] pins_sync;
  logic [DIRP_NUM_IRQ-1:0] user_lvl;
  logic [DIRP_NUM_IRQ-1:0] user_prev;
  logic [DIRP_NUM_IRQ-1:0] user_fall;
  logic nmi_lvl;
  logic nmi_prev;
  logic nmi_pend;
  logic reset_lvl;
  logic global_irq_mask_bit;
  logic irq_mode_bit;
  logic [DIRP_NUM_IRQ-1:0] irq_mask_reg;
  logic [DIRP_NUM_IRQ-1:0] irq_flag_reg;
  logic [DIRP_EVT_W-1:0] evt_status;
  logic [DIRP_EVT_W-1:0] evt_mask;
  logic [15:0] pc;
  dirp_state_t state;
  dirp_state_t next_state;
  logic [DIRP_NUM_IRQ-1:0] user_ready;
  logic [DIRP_IDX_W-1:0] user_pick;
  logic take_nmi;
  logic take_user;
  logic [DIRP_NUM_IRQ-1:0] take_clear;
  logic [DIRP_EVT_W-1:0] evt_set;
  logic wr_ctrl;
  logic wr_mask;
  logic wr_flag;
  logic wr_evt_mask;
  logic rd_evt;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // choose one pending user request; mode 0 favours line 0, mode 1 favours line 3
  function automatic logic [DIRP_IDX_W-1:0] pick_irq
  (
    input logic [DIRP_NUM_IRQ-1:0] ready,
    input logic mode
  );
    logic [DIRP_IDX_W-1:0] idx;
    idx = '0;
    for (int i = DIRP_NUM_IRQ - 1; i >= 0; i--)
    begin
      if (!mode && ready[i])
      begin
        idx = DIRP_IDX_W'(i);
      end
    end
    for (int i = 0; i < DIRP_NUM_IRQ; i++)
    begin
      if (mode && ready[i])
      begin
        idx = DIRP_IDX_W'(i);
      end
    end
    return idx;
  endfunction : pick_irq

  // vector location of a user interrupt line, four words apart
  function automatic logic [15:0] user_vector
  (
    input logic [DIRP_IDX_W-1:0] idx
  );
    return DIRP_USER_VEC_BASE + {12'h000, idx, 2'b00};
  endfunction : user_vector

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  // all active-low event and reset pins pass two flops first
  dirp_sync u_sync
  (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .async_in({reset_in_n, nmi_in_n, user_irq_in_3, user_irq_in_2, user_irq_in_1,
      user_irq_in_0}),
    .sync_out(pins_sync)
  );

  // split the synchronised vector into named levels
  assign user_lvl = pins_sync[DIRP_NUM_IRQ-1:0];
  assign nmi_lvl = pins_sync[DIRP_NUM_IRQ];
  assign reset_lvl = pins_sync[DIRP_NUM_IRQ+1];

  // previous levels for falling-edge detection
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      user_prev <= DIRP_SYNC_IDLE[DIRP_NUM_IRQ-1:0];
      nmi_prev <= 1'b1;
    end
    else if (ce)
    begin
      user_prev <= user_lvl;
      nmi_prev <= nmi_lvl;
    end
  end

  // a request is a high-to-low transition of a synchronised pin
  assign user_fall = user_prev & ~user_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // register port decode
  assign wr_ctrl = reg_wr && (reg_addr == DIRP_OFS_CTRL);
  assign wr_mask = reg_wr && (reg_addr == DIRP_OFS_MASK);
  assign wr_flag = reg_wr && (reg_addr == DIRP_OFS_FLAG);
  assign wr_evt_mask = reg_wr && (reg_addr == DIRP_OFS_EVT_MASK);
  assign rd_evt = reg_rd && (reg_addr == DIRP_OFS_EVT_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // arbitration

  // a user line is eligible when flagged, unmasked and globally enabled
  assign user_ready = global_irq_mask_bit ? '0 : (irq_flag_reg & irq_mask_reg);
  assign user_pick = pick_irq(user_ready, irq_mode_bit);
  // nmi ignores both the global mask and the mask register
  assign take_nmi = (state == DIRP_ST_RUN) && reset_lvl && nmi_pend;
  assign take_user = (state == DIRP_ST_RUN) && reset_lvl && !nmi_pend && (|user_ready);
  assign take_clear = take_user ? (DIRP_NUM_IRQ'(1) << user_pick) : '0;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  // next state: reset holds, run takes interrupts, vector lasts one cycle
  always_comb
  begin
    next_state = state;
    unique case (state)
      DIRP_ST_RESET:
      begin
        if (reset_lvl)
        begin
          next_state = DIRP_ST_RUN;
        end
      end
      DIRP_ST_RUN:
      begin
        if (!reset_lvl)
        begin
          next_state = DIRP_ST_RESET;
        end
        else if (take_nmi || take_user)
        begin
          next_state = DIRP_ST_VECTOR;
        end
      end
      DIRP_ST_VECTOR:
      begin
        next_state = reset_lvl ? DIRP_ST_RUN : DIRP_ST_RESET;
      end
      default:
      begin
        next_state = DIRP_ST_RESET;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= DIRP_ST_RESET;
    end
    else if (ce)
    begin
      state <= next_state;
    end
  end

  // program counter: pinned at the reset vector while reset is held
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pc <= DIRP_RESET_VEC;
    end
    else if (ce)
    begin
      if (!reset_lvl || state == DIRP_ST_RESET)
      begin
        pc <= DIRP_RESET_VEC;
      end
      else if (take_nmi)
      begin
        pc <= DIRP_NMI_VEC;
      end
      else if (take_user)
      begin
        pc <= user_vector(user_pick);
      end
      else
      begin
        pc <= pc + 16'h0001;
      end
    end
  end

  // fetch address lines follow the counter; first run cycle shows the reset vector
  assign addr_bus_out = pc;
  assign core_halted = (state == DIRP_ST_RESET);

  // acknowledge is low exactly in the vector-fetch cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_acknowledge_out <= 1'b1;
    end
    else if (ce)
    begin
      irq_acknowledge_out <= (next_state != DIRP_ST_VECTOR);
    end
  end

  // acknowledge driver released while output disable is low
  assign irq_acknowledge_oe = out_disable_n;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt bookkeeping

  // nmi pending latch; a new edge wins over the take
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      nmi_pend <= 1'b0;
    end
    else if (ce)
    begin
      if (!reset_lvl)
      begin
        nmi_pend <= 1'b0;
      end
      else if (nmi_prev && !nmi_lvl)
      begin
        nmi_pend <= 1'b1;
      end
      else if (take_nmi)
      begin
        nmi_pend <= 1'b0;
      end
    end
  end

  // flag register: edges set, write-one or service clears, set wins
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_flag_reg <= DIRP_FLAG_RESET;
    end
    else if (ce)
    begin
      if (!reset_lvl)
      begin
        irq_flag_reg <= DIRP_FLAG_RESET;
      end
      else
      begin
        irq_flag_reg <= (irq_flag_reg & ~take_clear
          & ~(wr_flag ? reg_wdata[DIRP_NUM_IRQ-1:0] : '0)) | user_fall;
      end
    end
  end

  // control bits; taking any interrupt sets the global mask, which wins
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      global_irq_mask_bit <= DIRP_GMASK_RESET;
      irq_mode_bit <= DIRP_MODE_RESET;
    end
    else if (ce)
    begin
      if (!reset_lvl)
      begin
        global_irq_mask_bit <= DIRP_GMASK_RESET;
      end
      else if (take_nmi || take_user)
      begin
        global_irq_mask_bit <= 1'b1;
      end
      else if (wr_ctrl)
      begin
        global_irq_mask_bit <= reg_wdata[DIRP_CTRL_GMASK_BIT];
      end
      if (wr_ctrl)
      begin
        irq_mode_bit <= reg_wdata[DIRP_CTRL_MODE_BIT];
      end
    end
  end

  // interrupt mask register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_mask_reg <= DIRP_MASK_RESET;
    end
    else if (ce && wr_mask)
    begin
      irq_mask_reg <= reg_wdata[DIRP_NUM_IRQ-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event status and interrupt output

  // events: user taken, nmi taken, reset released
  assign evt_set = {(state == DIRP_ST_RESET) && reset_lvl, take_nmi, take_user};

  // sticky status cleared by reading it; a same-cycle event survives
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      evt_status <= DIRP_EVT_RESET;
      evt_mask <= DIRP_EVT_RESET;
    end
    else if (ce)
    begin
      evt_status <= (rd_evt ? '0 : evt_status) | evt_set;
      if (wr_evt_mask)
      begin
        evt_mask <= reg_wdata[DIRP_EVT_W-1:0];
      end
    end
  end

  assign irq_out = |(evt_status & evt_mask);

  ////////////////////////////////////////////////////////////////////////////
  // register read data, one cycle after the strobe
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= DIRP_DATA_RESET;
    end
    else if (ce)
    begin
      reg_rdata <= DIRP_DATA_RESET;
      if (reg_rd)
      begin
        unique case (reg_addr)
          DIRP_OFS_CTRL: reg_rdata <= {14'h0000, irq_mode_bit, global_irq_mask_bit};
          DIRP_OFS_MASK: reg_rdata <= {12'h000, irq_mask_reg};
          DIRP_OFS_FLAG: reg_rdata <= {12'h000, irq_flag_reg};
          DIRP_OFS_EVT_STATUS: reg_rdata <= {13'h0000, evt_status};
          DIRP_OFS_EVT_MASK: reg_rdata <= {13'h0000, evt_mask};
          DIRP_OFS_PC: reg_rdata <= pc;
          default: reg_rdata <= DIRP_DATA_RESET;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data bus driver

  // bus driven only while running, not held, core driving and not disabled
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      data_bus_out <= DIRP_DATA_RESET;
      data_bus_oe <= 1'b0;
    end
    else if (ce)
    begin
      data_bus_out <= core_data_out;
      data_bus_oe <= core_data_drive && reset_lvl && hold_in_n && out_disable_n
        && (next_state != DIRP_ST_RESET);
    end
  end
endmodule : dirp_irq_reset

// ### dirp_checker.sv
// concurrent checks on the pins of the interrupt and reset block
`timescale 1ns/10ps
module dirp_checker
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic nmi_in_n,
  input wire logic reset_in_n,
  input wire logic hold_in_n,
  input wire logic out_disable_n,
  input wire logic [dirp_pkg::DIRP_DATA_W-1:0] core_data_out,
  input wire logic core_data_drive,
  input wire logic irq_acknowledge_out,
  input wire logic irq_acknowledge_oe,
  input wire logic [15:0] addr_bus_out,
  input wire logic [dirp_pkg::DIRP_DATA_W-1:0] data_bus_out,
  input wire logic data_bus_oe,
  input wire logic core_halted
);
  import dirp_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // one low cycle of the acknowledge pin
  sequence s_ack_pulse;
    !irq_acknowledge_out ##1 irq_acknowledge_out;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_ack_one_cycle: assert property (
    $fell(irq_acknowledge_out) |=> irq_acknowledge_out)
    else $error("acknowledge low too long");
  a_ack_oe_follow: assert property (
    irq_acknowledge_oe == out_disable_n)
    else $error("acknowledge enable wrong");
  a_ack_on_vector: assert property (
    !irq_acknowledge_out |-> addr_bus_out inside {16'hff88, 16'hffc0, 16'hffc4,
    16'hffc8, 16'hffcc})
    else $error("acknowledge off a vector");
  a_halt_pc_vec: assert property (
    core_halted |-> addr_bus_out == DIRP_RESET_VEC)
    else $error("halted pc not at reset vector");
  a_first_fetch: assert property (
    $fell(core_halted) |-> addr_bus_out == DIRP_RESET_VEC)
    else $error("first fetch not at reset vector");
  a_bus_release: assert property (
    (!core_data_drive || !hold_in_n || !out_disable_n) |=> !data_bus_oe)
    else $error("data bus still driven");
  a_bus_data_copy: assert property (
    data_bus_oe |-> data_bus_out == $past(core_data_out))
    else $error("data bus value wrong");
  a_reset_sync: assert property (
    $fell(reset_in_n) && !core_halted |=> !core_halted ##[1:3] core_halted)
    else $error("reset pin not taken through two flops");
  a_nmi_taken: assert property (
    $fell(nmi_in_n) && !core_halted |-> ##[2:8] s_ack_pulse)
    else $error("nmi not acknowledged");
endmodule : dirp_checker
// attach to every instance of the block
bind dirp_irq_reset dirp_checker u_chk (.core_clk, .rst, .nmi_in_n, .reset_in_n,
  .hold_in_n, .out_disable_n, .core_data_out, .core_data_drive, .irq_acknowledge_out,
  .irq_acknowledge_oe, .addr_bus_out, .data_bus_out, .data_bus_oe, .core_halted);

// ### dirp_source.sv
// model of the external interrupt sources and reset circuit
`timescale 1ns/10ps
module dirp_source
(
  input wire logic core_clk,
  output logic [3:0] user_irq_n,
  output logic nmi_n,
  output logic reset_n
);
  // all request pins rest high
  initial
  begin
    {reset_n, nmi_n, user_irq_n} = 6'h3f;
  end
  // pull chosen pins low for len cycles, short or long
  task pulse(input logic [5:0] pat, input int len);
    @(posedge core_clk);
    {reset_n, nmi_n, user_irq_n} <= ~pat;
    repeat (len) @(posedge core_clk);
    {reset_n, nmi_n, user_irq_n} <= 6'h3f;
  endtask : pulse
endmodule : dirp_source

// ### test_dsp_interrupt_reset_pins.sv
// self-checking bench for the interrupt and reset pin block
`timescale 1ns/10ps
module test_dsp_interrupt_reset_pins;
  import dirp_pkg::*;
  logic core_clk = 0, rst = 1, hold_in_n = 1, out_disable_n = 1, core_data_drive = 0;
  logic reg_wr = 0, reg_rd = 0, irq_acknowledge_out, irq_acknowledge_oe, data_bus_oe;
  logic core_halted, irq_out, nmi_n, reset_n;
  logic [3:0] reg_addr = 0, user_irq_n;
  logic [15:0] core_data_out = 0, reg_wdata = 0, reg_rdata, addr_bus_out, data_bus_out;
  logic [15:0] st = 16'h0016, v, e_dat;
  logic e_oe;
  int bad_count = 0, total_checks = 0, m;
  always #10 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  dirp_source src (.core_clk, .user_irq_n, .nmi_n, .reset_n);
  dirp_irq_reset dut (.core_clk, .rst, .ce(1'b1), .user_irq_in_0(user_irq_n[0]),
    .user_irq_in_1(user_irq_n[1]), .user_irq_in_2(user_irq_n[2]),
    .user_irq_in_3(user_irq_n[3]), .nmi_in_n(nmi_n), .reset_in_n(reset_n), .hold_in_n,
    .out_disable_n, .core_data_out, .core_data_drive, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq_acknowledge_out, .irq_acknowledge_oe, .addr_bus_out,
    .data_bus_out, .data_bus_oe, .core_halted, .irq_out);
  ////////////////////////////////////////////////////////////////////////////////
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function logic cond(input int k);
    if (k == 0)
      return irq_acknowledge_out === 1'b0;
    return core_halted === (k == 1);
  endfunction : cond
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // bounded wait: 0 acknowledge low, 1 halted, 2 running
  task wait_on(input int k);
    int n;
    n = 0;
    #1;
    while (!cond(k) && n < 40)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 40)
    begin
      bad_count++;
      $display("[FAIL] wait %0d expected 1 seen 0", k);
      close_out();
    end
  endtask : wait_on
  // guard against a hung run
  initial
  begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    $display("[FAIL] run expected end seen timeout");
    close_out();
  end
  // main sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    wait_on(2);
    // leaving reset counts as a release event, so clear it before the interrupt tests
    rd(DIRP_OFS_EVT_STATUS, v);
    chk("power-up event", v, 16'h0004);
    rd(DIRP_OFS_CTRL, v);
    chk("ctrl reset", v, 16'h0001);
    rd(DIRP_OFS_MASK, v);
    chk("mask reset", v, 16'h0000);
    rd(4'hf, v);
    chk("unmapped", v, 16'h0000);
    st = lfsr(st);
    src.pulse(6'h01 << st[1:0], 2);
    repeat (3) @(posedge core_clk);
    rd(DIRP_OFS_FLAG, v);
    chk("flag set", v, 16'h0001 << st[1:0]);
    wr(DIRP_OFS_FLAG, 16'h0001 << st[1:0]);
    rd(DIRP_OFS_FLAG, v);
    chk("flag clear", v, 16'h0000);
    $display("flag test done");
    wr(DIRP_OFS_MASK, 16'h000f);
    for (m = 0; m < 2; m++)
    begin
      src.pulse(6'h09, 2);
      repeat (3) @(posedge core_clk);
      wr(DIRP_OFS_CTRL, {14'h0000, m[0], 1'b0});
      wait_on(0);
      chk("first vector", addr_bus_out, DIRP_USER_VEC_BASE + (m ? 16'h000c : 16'h0000));
      wr(DIRP_OFS_CTRL, {14'h0000, m[0], 1'b0});
      wait_on(0);
      chk("second vector", addr_bus_out, DIRP_USER_VEC_BASE + (m ? 16'h0000 : 16'h000c));
      rd(DIRP_OFS_EVT_STATUS, v);
      chk("user event", v, 16'h0001);
    end
    $display("priority test done");
    wr(DIRP_OFS_MASK, 16'h0000);
    wr(DIRP_OFS_EVT_MASK, 16'h0002);
    src.pulse(6'h10, 2);
    wait_on(0);
    chk("nmi vector", addr_bus_out, DIRP_NMI_VEC);
    chk("irq raised", {15'h0000, irq_out}, 16'h0001);
    wr(DIRP_OFS_EVT_MASK, 16'h0000);
    #1;
    chk("irq masked", {15'h0000, irq_out}, 16'h0000);
    rd(DIRP_OFS_EVT_STATUS, v);
    chk("nmi event", v, 16'h0002);
    $display("nmi test done");
    wr(DIRP_OFS_EVT_MASK, 16'h0004);
    core_data_drive <= 1'b1;
    src.pulse(6'h20, 6);
    #1;
    chk("halted", {15'h0000, core_halted}, 16'h0001);
    chk("halted pc", addr_bus_out, DIRP_RESET_VEC);
    chk("bus off", {15'h0000, data_bus_oe}, 16'h0000);
    wait_on(2);
    chk("first fetch", addr_bus_out, DIRP_RESET_VEC);
    @(posedge core_clk);
    #1;
    chk("next fetch", addr_bus_out, DIRP_RESET_VEC + 16'h0001);
    // counter is sampled one edge after the fetch above
    rd(DIRP_OFS_PC, v);
    chk("pc readback", v, DIRP_RESET_VEC + 16'h0002);
    chk("irq reset event", {15'h0000, irq_out}, 16'h0001);
    rd(DIRP_OFS_CTRL, v);
    chk("gmask after reset", v & 16'h0001, 16'h0001);
    rd(DIRP_OFS_EVT_STATUS, v);
    chk("reset event", v, 16'h0004);
    #1;
    chk("irq cleared", {15'h0000, irq_out}, 16'h0000);
    $display("reset test done");
    // the core is still driving from the reset test, so the bus starts enabled
    e_oe = hold_in_n & out_disable_n & core_data_drive;
    e_dat = core_data_out;
    for (m = 0; m < 150; m++)
    begin
      @(posedge core_clk);
      st = lfsr(st);
      {hold_in_n, out_disable_n, core_data_drive} <= st[2:0];
      core_data_out <= st;
      #1;
      chk("bus enable", {15'h0000, data_bus_oe}, {15'h0000, e_oe});
      if (e_oe)
        chk("bus data", data_bus_out, e_dat);
      chk("ack enable", {15'h0000, irq_acknowledge_oe}, {15'h0000, st[1]});
      e_oe = &st[2:0];
      e_dat = st;
    end
    $display("bus test done");
    close_out();
  end
endmodule : test_dsp_interrupt_reset_pins
